// [logic/chan_cfg_defs.vh]
`ifndef CHAN_CFG_DEFS_VH
`define CHAN_CFG_DEFS_VH

// register byte offsets
`define REG_CFG      5'h00
`define REG_DATA     5'h04
`define REG_BCAST    5'h08
`define REG_MLOW     5'h0C
`define REG_MHIGH    5'h10
`define REG_CTRL     5'h14
`define REG_STAT     5'h18

// channel_function_config fields
`define CFG_RESET    16'h0000
`define CFG_CLR_SEL  15
`define CFG_DEFER    14
`define CFG_BCAST    13
`define CFG_PH_HI    12
`define CFG_PH_LO    11
`define CFG_WV_HI    10
`define CFG_WV_LO    8
`define CFG_LOG      7
`define CFG_STEP_HI  6
`define CFG_STEP_LO  4
`define CFG_RATE_HI  3
`define CFG_RATE_LO  0
`define CFG_FALL_HI  3
`define CFG_FALL_LO  1

// control register bits
`define CTRL_LOAD    0
`define CTRL_CLEAR   1
`define CTRL_HIGH    2
`define CTRL_RUN     3

// data field of data and broadcast writes
`define DATA_HI      15
`define DATA_LO      4

`define CODE_ZERO    12'h000
`define CODE_MID     12'h800

// waveform codes
`define WAVE_TRI     3'h0
`define WAVE_SAW     3'h1
`define WAVE_INV     3'h2
`define WAVE_SINE    3'h4
`define WAVE_OFF     3'h7

// step intervals in ns, index 1..15
`define CLK_NS       20
`define T_I1         4000
`define T_I2         8000
`define T_I3         12000
`define T_I4         18000
`define T_I5         27040
`define T_I6         40480
`define T_I7         60720
`define T_I8         91120
`define T_I9         136720
`define T_I10        239200
`define T_I11        418640
`define T_I12        732560
`define T_I13        1282000
`define T_I14        2563960
`define T_I15        5127920

`endif

// [logic/slew_interval_timer.v]
`timescale 1ns/10ps
`include "chan_cfg_defs.vh"

module slew_interval_timer #(
    parameter integer CYCLE_NS = `CLK_NS
) (
    input  wire        clk,
    input  wire        srst,
    input  wire        ce,
    input  wire        run,
    input  wire        restart,
    input  wire [3:0]  rate,
    output wire        tick
);
    reg [17:0] reload;
    reg [17:0] cnt_reg;

    function [17:0] cyc;
        input integer t;
        integer c;
        begin
            c = t / CYCLE_NS;
            if (c < 1)
                c = 1;
            cyc = c[17:0];
        end
    endfunction

    // interval table
    always @*
    begin
        case (rate)
            4'h1: reload = cyc(`T_I1);
            4'h2: reload = cyc(`T_I2);
            4'h3: reload = cyc(`T_I3);
            4'h4: reload = cyc(`T_I4);
            4'h5: reload = cyc(`T_I5);
            4'h6: reload = cyc(`T_I6);
            4'h7: reload = cyc(`T_I7);
            4'h8: reload = cyc(`T_I8);
            4'h9: reload = cyc(`T_I9);
            4'hA: reload = cyc(`T_I10);
            4'hB: reload = cyc(`T_I11);
            4'hC: reload = cyc(`T_I12);
            4'hD: reload = cyc(`T_I13);
            4'hE: reload = cyc(`T_I14);
            4'hF: reload = cyc(`T_I15);
            default: reload = 18'h00001;
        endcase
    end

    assign tick = run & ~restart & (cnt_reg == 18'h00000);

    always @(posedge clk)
    begin
        if (srst)
            cnt_reg <= 18'h00000;
        else if (ce)
        begin
            if (restart | ~run | tick)
                cnt_reg <= reload - 18'h00001; // R18
            else
                cnt_reg <= cnt_reg - 18'h00001;
        end
    end
endmodule // slew_interval_timer

// [logic/slew_step_engine.v]
`timescale 1ns/10ps

module slew_step_engine (
    input  wire [11:0] code,
    input  wire [11:0] target,
    input  wire        log_mode,
    input  wire [2:0]  step_sel,
    output reg  [11:0] next_code
);
    reg  [12:0] delta;
    wire [12:0] sum  = {1'b0, code} + delta;
    wire        rise = target > code;

    always @*
    begin
        if (log_mode)
        begin
            // 1/32 of current code per step, at least one code
            delta = {6'h00, code[11:5]}; // R11 R12
            if (delta == 13'h0000)
                delta = 13'h0001;
        end
        else
        begin
            case (step_sel) // R8
                3'h0: delta = 13'h0001;
                3'h1: delta = 13'h0002;
                3'h2: delta = 13'h0003;
                3'h3: delta = 13'h0004;
                3'h4: delta = 13'h0006;
                3'h5: delta = 13'h0008;
                3'h6: delta = 13'h0010;
                default: delta = 13'h0020;
            endcase
        end
        if (rise)
            next_code = (sum > {1'b0, target}) ? target : sum[11:0]; // R19
        else if ({1'b0, code} < ({1'b0, target} + delta))
            next_code = target; // R19
        else
            next_code = code - delta[11:0];
    end
endmodule // slew_step_engine

// [logic/dac_channel_wave_slew_config.v]
// What this block does
// R1: clear loads zero or mid scale
// R2: immediate mode updates output after write
// R3: deferred mode waits for load pin or bit
// R4: broadcast writes only when accept bit set
// R5: phase field picks waveform start phase
// R6: waveform field picks shape or off
// R7: geometric bit picks linear or log slew
// R8: linear step field sets code increment
// R9: linear interval field sets step period
// R10: interval zero jumps; not for waveforms
// R11: log rising steps grow by 1.03125
// R12: log falling steps shrink by 0.96875
// R13: log slew from zero starts at one
// R14: rising interval field sets upward period
// R15: falling interval field sets downward period
// R16: direction chooses rising or falling interval
// R17: load bit hits deferred channels, self-clears
// R18: step timer reloads from interval table
// R19: steps clamp at the target bound
`timescale 1ns/10ps
`include "chan_cfg_defs.vh"

module dac_channel_wave_slew_config #(
    parameter integer CYCLE_NS = `CLK_NS
) (
    input  wire        clk,
    input  wire        srst,
    input  wire        ce,
    input  wire [4:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output wire [31:0] readdata,
    output wire        waitrequest,
    input  wire        load_trigger_n,
    input  wire        clear_req,
    output wire [11:0] dac_code,
    output wire        slew_busy
);
    localparam [1:0] ST_HOLD = 2'd0;
    localparam [1:0] ST_SLEW = 2'd1;
    localparam [1:0] ST_WAVE = 2'd2;

    reg  [15:0] cfg_reg;
    reg  [11:0] pend_reg;
    reg         pend_valid_reg;
    reg  [11:0] mlow_reg;
    reg  [11:0] mhigh_reg;
    reg         high_sel_reg;
    reg  [11:0] code_reg;
    reg  [11:0] target_reg;
    reg         rise_reg;
    reg  [1:0]  state_reg;
    reg         load_pin_reg;
    reg         ack_reg;
    reg  [31:0] rdata_reg;
    reg         restart_reg;
    reg  [31:0] rdata_next;
    reg  [3:0]  rate_sel;
    reg  [4:0]  phase_num;
    reg  [11:0] wave_start;
    reg         wave_rise;

    wire        wr_ok     = write & ack_reg;
    wire        log_mode  = cfg_reg[`CFG_LOG];
    wire        defer     = cfg_reg[`CFG_DEFER];
    wire [2:0]  wave_sel  = cfg_reg[`CFG_WV_HI:`CFG_WV_LO];
    wire [1:0]  phase_sel = cfg_reg[`CFG_PH_HI:`CFG_PH_LO];
    wire [2:0]  rise_sel  = cfg_reg[`CFG_STEP_HI:`CFG_STEP_LO];
    wire [2:0]  fall_sel  = cfg_reg[`CFG_FALL_HI:`CFG_FALL_LO];
    wire [3:0]  lin_rate  = cfg_reg[`CFG_RATE_HI:`CFG_RATE_LO];
    wire [11:0] wdata     = writedata[`DATA_HI:`DATA_LO];
    wire [11:0] span      = mhigh_reg - mlow_reg;
    wire [23:0] offset    = ({12'h000, span} * {19'h00000, phase_num} * 24'h0000AB) >> 11;
    wire        no_slew   = ~log_mode & (lin_rate == 4'h0);
    wire        wave_ok   = (wave_sel == `WAVE_TRI) | (wave_sel == `WAVE_SAW) |
                            (wave_sel == `WAVE_INV) | (wave_sel == `WAVE_SINE);
    wire        is_tri    = (wave_sel == `WAVE_TRI) | (wave_sel == `WAVE_SINE);
    wire        pin_fall  = load_pin_reg & ~load_trigger_n;
    wire        bit_load  = wr_ok & (address == `REG_CTRL) & writedata[`CTRL_LOAD];
    wire        do_load   = (pin_fall | bit_load) & defer & pend_valid_reg; // R3 R17
    wire        do_clear  = clear_req | (wr_ok & (address == `REG_CTRL) & writedata[`CTRL_CLEAR]);
    wire        data_wr   = wr_ok & ((address == `REG_DATA) |
                            ((address == `REG_BCAST) & cfg_reg[`CFG_BCAST])); // R4
    wire        ctrl_wr   = wr_ok & (address == `REG_CTRL);
    wire        tick;
    wire [11:0] eng_next;
    wire [11:0] eng_target = (state_reg == ST_WAVE) ? (rise_reg ? mhigh_reg : mlow_reg) : target_reg;
    wire        going_up  = (state_reg == ST_WAVE) ? rise_reg : (target_reg > code_reg);

    assign waitrequest = (read | write) & ~(ack_reg & ce);
    assign readdata    = rdata_reg;
    assign dac_code    = code_reg;
    assign slew_busy   = state_reg != ST_HOLD;

    // step period select
    always @*
    begin
        if (log_mode)
            rate_sel = going_up ? {rise_sel, 1'b1} : {fall_sel, 1'b1}; // R14 R15 R16
        else
            rate_sel = lin_rate; // R9
    end

    // waveform start point
    always @*
    begin
        case (phase_sel) // R5
            2'h0: phase_num = 5'd0;
            2'h1: phase_num = 5'd4;
            2'h2: phase_num = 5'd8;
            default: phase_num = 5'd3;
        endcase
        wave_rise = 1'b1;
        if (is_tri)
        begin
            if (phase_num < 5'd6)
                phase_num = {phase_num[3:0], 1'b0};
            else
            begin
                phase_num = 5'd24 - {phase_num[3:0], 1'b0};
                wave_rise = 1'b0;
            end
        end
        if (wave_sel == `WAVE_INV)
        begin
            wave_start = mhigh_reg - offset[11:0];
            wave_rise  = 1'b0;
        end
        else
            wave_start = mlow_reg + offset[11:0];
    end

    // register read mux
    always @*
    begin
        case (address)
            `REG_CFG:   rdata_next = {16'h0000, cfg_reg};
            `REG_DATA:  rdata_next = {16'h0000, pend_reg, 4'h0};
            `REG_MLOW:  rdata_next = {16'h0000, mlow_reg, 4'h0};
            `REG_MHIGH: rdata_next = {16'h0000, mhigh_reg, 4'h0};
            `REG_CTRL:  rdata_next = {28'h0000000, state_reg == ST_WAVE, high_sel_reg, 2'h0};
            `REG_STAT:  rdata_next = {16'h0000, rise_reg, state_reg, pend_valid_reg, code_reg};
            default:    rdata_next = 32'h00000000;
        endcase
    end

    slew_interval_timer #(
        .CYCLE_NS (CYCLE_NS)
    ) u_timer (
        .clk     (clk),
        .srst    (srst),
        .ce      (ce),
        .run     (state_reg != ST_HOLD),
        .restart (restart_reg),
        .rate    (rate_sel),
        .tick    (tick)
    );

    slew_step_engine u_engine (
        .code      (code_reg),
        .target    (eng_target),
        .log_mode  (log_mode),
        .step_sel  (rise_sel),
        .next_code (eng_next)
    );

    // bus handshake
    always @(posedge clk)
    begin
        if (srst)
        begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end
        else if (ce)
        begin
            ack_reg <= (read | write) & ~ack_reg;
            if (read & ~ack_reg)
                rdata_reg <= rdata_next;
        end
    end

    // configuration and bounds
    always @(posedge clk)
    begin
        if (srst)
        begin
            cfg_reg      <= `CFG_RESET;
            mlow_reg     <= `CODE_ZERO;
            mhigh_reg    <= `CODE_ZERO;
            load_pin_reg <= 1'b1;
        end
        else if (ce)
        begin
            load_pin_reg <= load_trigger_n;
            if (wr_ok & (address == `REG_CFG))
                cfg_reg <= writedata[15:0];
            if (wr_ok & (address == `REG_MLOW))
                mlow_reg <= wdata;
            if (wr_ok & (address == `REG_MHIGH))
                mhigh_reg <= wdata;
        end
    end

    // output sequencing
    always @(posedge clk)
    begin
        if (srst)
        begin
            code_reg       <= `CODE_ZERO;
            target_reg     <= `CODE_ZERO;
            pend_reg       <= `CODE_ZERO;
            pend_valid_reg <= 1'b0;
            high_sel_reg   <= 1'b0;
            rise_reg       <= 1'b1;
            state_reg      <= ST_HOLD;
            restart_reg    <= 1'b0;
        end
        else if (ce)
        begin
            restart_reg <= 1'b0;
            if (do_load)
            begin
                code_reg       <= pend_reg; // R3 R17
                pend_valid_reg <= 1'b0;
                state_reg      <= ST_HOLD;
            end
            if (data_wr)
            begin
                if (defer)
                begin
                    pend_reg       <= wdata; // R3
                    pend_valid_reg <= 1'b1;
                end
                else
                begin
                    code_reg  <= wdata; // R2
                    state_reg <= ST_HOLD;
                end
            end
            if (ctrl_wr)
            begin
                high_sel_reg <= writedata[`CTRL_HIGH];
                if (writedata[`CTRL_RUN] & wave_ok & ~no_slew) // R6 R10
                begin
                    code_reg    <= wave_start;
                    rise_reg    <= wave_rise;
                    state_reg   <= ST_WAVE;
                    restart_reg <= 1'b1;
                end
                else if (~writedata[`CTRL_RUN] & (state_reg == ST_WAVE))
                    state_reg <= ST_HOLD;
                else if (writedata[`CTRL_HIGH] != high_sel_reg)
                begin
                    target_reg <= writedata[`CTRL_HIGH] ? mhigh_reg : mlow_reg;
                    if (no_slew)
                    begin
                        code_reg  <= writedata[`CTRL_HIGH] ? mhigh_reg : mlow_reg; // R10
                        state_reg <= ST_HOLD;
                    end
                    else
                    begin
                        if (log_mode & (code_reg == `CODE_ZERO))
                            code_reg <= 12'h001; // R13
                        state_reg   <= ST_SLEW; // R7
                        restart_reg <= 1'b1;
                    end
                end
            end
            if (tick & ~data_wr & ~do_load & ~ctrl_wr)
            begin
                case (state_reg)
                    ST_SLEW:
                    begin
                        code_reg <= eng_next; // R19
                        if (eng_next == target_reg)
                            state_reg <= ST_HOLD;
                    end
                    ST_WAVE:
                    begin
                        if ((wave_sel == `WAVE_SAW) & (code_reg == mhigh_reg))
                            code_reg <= mlow_reg;
                        else if ((wave_sel == `WAVE_INV) & (code_reg == mlow_reg))
                            code_reg <= mhigh_reg;
                        else if (is_tri & (code_reg == eng_target))
                            rise_reg <= ~rise_reg;
                        else
                            code_reg <= eng_next; // R11 R12
                    end
                    default:
                        state_reg <= ST_HOLD;
                endcase
            end
            if (do_clear)
            begin
                code_reg  <= cfg_reg[`CFG_CLR_SEL] ? `CODE_MID : `CODE_ZERO; // R1
                state_reg <= ST_HOLD;
            end
        end
    end
endmodule // dac_channel_wave_slew_config

// [tb/dac_channel_wave_slew_config_monitor.sv]
`timescale 1ns/10ps
`include "chan_cfg_defs.vh"

module dac_channel_wave_slew_config_monitor #(
    parameter integer CYCLE_NS = 20
) (
    input wire        clk,
    input wire        srst,
    input wire        ce,
    input wire [4:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire        load_trigger_n,
    input wire        clear_req,
    input wire [11:0] dac_code,
    input wire        slew_busy
);
    reg [15:0] cfg_reg;
    wire       req     = read || write;
    wire       wr_done = write && !waitrequest;
    wire       rd_done = read && !waitrequest;

    // shadow of the configuration word
    always @(posedge clk)
    begin
        if (srst)
            cfg_reg <= 16'h0000;
        else if (ce && wr_done && address == `REG_CFG)
            cfg_reg <= writedata[15:0];
    end

    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (srst || !ce);

    wait_first_a: assert property (req && !$past(req) |-> waitrequest)
        else $error("waitrequest low in first request cycle");
    wait_one_a: assert property (req && waitrequest |=> !waitrequest)
        else $error("more than one wait state");
    wait_idle_a: assert property (!req |-> !waitrequest)
        else $error("waitrequest high without request");
    clear_level_a: assert property (clear_req |=> dac_code == ($past(cfg_reg[15]) ? `CODE_MID : `CODE_ZERO))
        else $error("clear loaded wrong code");
    clear_stop_a: assert property (clear_req |=> !slew_busy)
        else $error("clear did not stop activity");
    immediate_a: assert property (wr_done && address == `REG_DATA && !cfg_reg[14] && !clear_req && !slew_busy
        |=> dac_code == $past(writedata[15:4]))
        else $error("immediate write not applied");
    defer_hold_a: assert property (wr_done && address == `REG_DATA && cfg_reg[14] && !clear_req && !slew_busy
        && load_trigger_n && $past(load_trigger_n) |=> $stable(dac_code))
        else $error("deferred write changed output");
    bcast_ignore_a: assert property (wr_done && address == `REG_BCAST && !cfg_reg[13] && !clear_req
        && !slew_busy && load_trigger_n |=> $stable(dac_code))
        else $error("broadcast not ignored");
    load_self_clear_a: assert property (rd_done && address == `REG_CTRL |-> readdata[1:0] == 2'b00)
        else $error("trigger bits read back set");
    unmapped_read_a: assert property (rd_done && address > `REG_STAT |-> readdata == 32'h00000000)
        else $error("unmapped read not zero");

    cover property (wr_done && address == `REG_CTRL && writedata[2]);
    cover property ($fell(slew_busy));
    cover property (clear_req && cfg_reg[15]);
    cover property (wr_done && address == `REG_DATA && cfg_reg[14]);
endmodule // dac_channel_wave_slew_config_monitor

bind dac_channel_wave_slew_config dac_channel_wave_slew_config_monitor #(.CYCLE_NS(CYCLE_NS)) u_monitor (
    .clk(clk), .srst(srst), .ce(ce), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .load_trigger_n(load_trigger_n), .clear_req(clear_req), .dac_code(dac_code), .slew_busy(slew_busy));

// [tb/dac_channel_wave_slew_config_test.sv]
`timescale 1ns/10ps
`include "chan_cfg_defs.vh"

module dac_channel_wave_slew_config_test;
    reg         clk            = 1'b0;
    reg         srst           = 1'b1;
    reg         ce             = 1'b1;
    reg  [4:0]  address        = 5'h00;
    reg         read           = 1'b0;
    reg         write          = 1'b0;
    reg  [31:0] writedata      = 32'h00000000;
    reg         load_trigger_n = 1'b1;
    reg         clear_req      = 1'b0;
    wire [31:0] readdata;
    wire        waitrequest;
    wire [11:0] dac_code;
    wire        slew_busy;
    integer     fails          = 0;
    integer     n_compared     = 0;
    integer     i;
    integer     j;
    reg  [31:0] rdv;
    reg  [11:0] ph [0:3];
    reg  [5:0]  steps [0:7];
    reg  [2:0]  waves [0:3];

    dac_channel_wave_slew_config #(.CYCLE_NS(4000)) u_dut (
        .clk(clk), .srst(srst), .ce(ce), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .load_trigger_n(load_trigger_n), .clear_req(clear_req), .dac_code(dac_code), .slew_busy(slew_busy));

    initial
    begin
        forever #10 clk = ~clk;
    end

    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("ERROR %0s expected %0h seen %0h", nm, e, g);
        end
    end
    endtask

    task results;
    begin
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    task bus(input w, input [4:0] a, input [31:0] d);
    begin
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        rdv = readdata;
        write <= 1'b0;
        read <= 1'b0;
        #1;
    end
    endtask

    task wr(input [4:0] a, input [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input [4:0] a);
        bus(1'b0, a, 32'h00000000);
    endtask

    task tick(input integer k);
    begin
        repeat (k) @(posedge clk);
        #1;
    end
    endtask

    task clr;
    begin
        @(posedge clk) clear_req <= 1'b1;
        @(posedge clk) clear_req <= 1'b0;
        #1;
    end
    endtask

    // follows a slew step by step, checking code and spacing
    task slew(input [11:0] tgt, input integer gap, input lg, input integer stp);
        integer n, k, p, e, d;
    begin
        p = dac_code;
        k = 0;
        while (p != tgt && k < 400)
        begin
            n = 0;
            while (dac_code === p && n < 3000)
            begin
                tick(1);
                n = n + 1;
            end
            d = lg ? (((p >> 5) > 0) ? (p >> 5) : 1) : stp;
            e = (p == 0 && lg) ? 1 : ((tgt > p) ? p + d : p - d);
            if ((tgt > p) ? (e > tgt) : (e < tgt))
                e = tgt;
            chk("dac_code", e, dac_code);
            if (k > 0)
                chk("step_gap", gap, n);
            p = dac_code;
            k = k + 1;
        end
    end
    endtask

    initial
    begin
        steps = '{1, 2, 3, 4, 6, 8, 16, 32};
        waves = '{`WAVE_TRI, `WAVE_SAW, `WAVE_INV, `WAVE_SINE};
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(`REG_CFG);
        chk("cfg_reset", `CFG_RESET, rdv);
        wr(`REG_CFG, 32'h0000FFFF);
        rd(`REG_CFG);
        chk("cfg_rw", 32'h0000FFFF, rdv);
        rd(5'h1C);
        chk("unmapped", 32'h00000000, rdv);
        wr(`REG_CFG, 32'h00000000);
        wr(`REG_DATA, 32'h00001230);
        chk("dac_code", 12'h123, dac_code);
        clr;
        chk("dac_code", 12'h000, dac_code);
        wr(`REG_CFG, 32'h00008000);
        clr;
        chk("dac_code", 12'h800, dac_code);
        wr(`REG_CFG, 32'h00004000);
        wr(`REG_DATA, 32'h00004560);
        chk("dac_code", 12'h800, dac_code);
        @(posedge clk) load_trigger_n <= 1'b0;
        repeat (3) @(posedge clk);
        load_trigger_n <= 1'b1;
        tick(3);
        chk("dac_code", 12'h456, dac_code);
        wr(`REG_DATA, 32'h00007890);
        chk("dac_code", 12'h456, dac_code);
        wr(`REG_CTRL, 32'h00000001);
        tick(1);
        chk("dac_code", 12'h789, dac_code);
        rd(`REG_CTRL);
        chk("ctrl_load", 1'b0, rdv[0]);
        wr(`REG_BCAST, 32'h00003210);
        chk("dac_code", 12'h789, dac_code);
        wr(`REG_CFG, 32'h00002000);
        wr(`REG_BCAST, 32'h00003210);
        chk("dac_code", 12'h321, dac_code);
        wr(`REG_CTRL, 32'h00000002);
        chk("dac_code", 12'h000, dac_code);
        wr(`REG_MLOW, 32'h00000000);
        wr(`REG_MHIGH, 32'h00000F00);
        clr;
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(`REG_CFG, (i << 4) | 4);
            wr(`REG_CTRL, 32'h00000004);
            slew(12'h0F0, 4, 1'b0, steps[i]);
            wr(`REG_CFG, i << 4);
            wr(`REG_CTRL, 32'h00000000);
            tick(2);
            chk("dac_code", 12'h000, dac_code);
        end
        wr(`REG_CFG, 32'h000000A6);
        wr(`REG_MHIGH, 32'h00000800);
        wr(`REG_CTRL, 32'h00000004);
        chk("dac_code", 12'h001, dac_code);
        slew(12'h080, 6, 1'b1, 0);
        wr(`REG_CTRL, 32'h00000000);
        slew(12'h000, 15, 1'b1, 0);
        wr(`REG_MHIGH, 32'h00001000);
        for (i = 0; i < 4; i = i + 1)
            for (j = 0; j < 4; j = j + 1)
            begin
                clr;
                wr(`REG_CFG, (j << 11) | (waves[i] << 8) | 32'h00000071);
                wr(`REG_CTRL, 32'h00000008);
                chk("wave_busy", 1'b1, slew_busy);
                if (i == 0)
                    ph[j] = dac_code;
                if (i == 0 && j == 2)
                begin
                    rd(`REG_STAT);
                    chk("wave_dir", 1'b0, rdv[15]);
                end
                if (i == 1 && j == 0)
                begin
                    tick(3);
                    chk("wave_code", 12'h040, dac_code);
                    @(posedge clk) ce <= 1'b0;
                    tick(4);
                    chk("ce_freeze", 12'h060, dac_code);
                    @(posedge clk) ce <= 1'b1;
                end
            end
        clr;
        chk("phase_start", 12'h000, ph[0]);
        chk("phase_start", 12'h0AB, ph[1]);
        chk("phase_start", 12'h0AB, ph[2]);
        chk("phase_start", 12'h080, ph[3]);
        wr(`REG_CFG, 32'h00000771);
        wr(`REG_CTRL, 32'h00000008);
        chk("wave_busy", 1'b0, slew_busy);
        wr(`REG_CFG, 32'h00000070);
        wr(`REG_CTRL, 32'h00000008);
        chk("wave_busy", 1'b0, slew_busy);
        clr;
        results;
    end

    initial
    begin
        #(40000 * 20);
        fails = fails + 1;
        results;
    end
endmodule // dac_channel_wave_slew_config_test
